/* logic/ast_edge_sync.v */
/*
  Two-flop synchroniser with selectable-edge detector for one input.
  Assumes the input is asynchronous and the clock is i_clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ast_edge_sync
(
  input  wire i_clock,     // Engine clock
  input  wire i_reset_n,   // Synchronous reset, active low
  input  wire i_level,     // Raw input
  input  wire i_falling,   // 1 selects falling edge
  output wire o_edge       // One-cycle pulse on chosen edge
);
  reg meta_q;   // First stage, read only by second
  reg sync_q;   // Second stage
  reg prev_q;   // Delayed copy for edge compare

  // Synchronise then remember last level
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_level;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge picked by polarity select
  assign o_edge = i_falling ? (prev_q & ~sync_q) : (sync_q & ~prev_q);
endmodule // ast_edge_sync
`default_nettype wire

/* logic/ast_map.vh */
/*
  Constant map of the analog-input sample timing engine: source selects,
  timebase selects, widths and timing counts.
  Assumes inclusion by bare name from the engine's design files.
*/
`ifndef AST_MAP_VH
`define AST_MAP_VH

// Sample pulse source selects (5 bits)
`define AST_SRC_COUNTER     5'h00
`define AST_SRC_DIVIDED     5'h01
`define AST_SRC_SOFTWARE    5'h02
`define AST_SRC_LINE0       5'h03
`define AST_SRC_SYNC0       5'h09
`define AST_SRC_STAR        5'h11
// Timebase selects (5 bits)
`define AST_TB_20MHZ        5'h00
`define AST_TB_100KHZ       5'h01
`define AST_TB_BP10MHZ      5'h02
`define AST_TB_SYNC0        5'h03
`define AST_TB_LINE0        5'h0B
`define AST_TB_STAR         5'h11
// Counts
`define AST_NUM_IN_LINES    6
`define AST_NUM_OUT_LINES   4
`define AST_NUM_SYNC        8
`define AST_CLK_HZ          20000000
`define AST_TB100K_HZ       100000
`define AST_TB100K_DIV      (`AST_CLK_HZ / `AST_TB100K_HZ)
`define AST_TB100K_LAST     8'hC7
`define AST_START_DLY_RST   16'h0002
`define AST_PULSE_CYC       4'h2

`endif

/* logic/ast_timing_engine.v */
/*
  Analog-input sample timing engine: timebase and sample pulse selection,
  divider, start delay, acquisition gating, sample counter, routed output.
  Assumes external lines, sync bus, star and backplane clock are plain inputs
  sampled on i_clock; conversion pulses come from the convert logic.
*/
// Behaviour
// - Accepted sample pulse measures every channel
// - Sample edge polarity is selectable
// - Sample source among counter, divider, software, lines
// - Divided source uses programmable timebase counter
// - Sample routable to outputs 6..9, sync; active high
// - Routed output in pulse or level form
// - Lines 0..5 inputs, 6..9 outputs only
// - Sample pulses ignored outside acquisition
// - Pause gate blocks sample pulses
// - Start trigger starts counter; finite end stops
// - Start delay configurable, default two ticks
// - Post-trigger: load count, decrement, end zero
// - Pre-trigger: load pre count, then post count
// - Early reference trigger is ignored
// - After reference, count post samples then end
// - Software start emits pulse on start line
// - Timebase selectable among listed sources
// - Timebase never routed to connector outputs
// - Timebase edge polarity selectable
// - Busy until convert count; stray converts ignored
`timescale 1ns/1ns
`default_nettype none
`include "ast_map.vh"
module ast_timing_engine
#(
  parameter CNT_W = 24,   // Sample counter width
  parameter DIV_W = 24    // Timebase divider width
)
(
  input  wire             i_clock,            // 20 MHz engine clock
  input  wire             i_reset_n,          // Synchronous reset, active low
  input  wire [5:0]       i_function_line,    // Input-only function lines 0..5
  input  wire [7:0]       i_sync_bus_line,    // Sync bus lines 0..7
  input  wire             i_star_line,        // Backplane star line
  input  wire             i_bp_clk10,         // Backplane 10 MHz clock
  input  wire             i_counter_out,      // Internal counter output
  input  wire             i_sw_sample,        // Host software sample pulse
  input  wire [4:0]       i_sample_src,       // Sample pulse source select
  input  wire             i_sample_falling,   // Sample edge polarity
  input  wire [4:0]       i_timebase_src,     // Timebase source select
  input  wire             i_timebase_falling, // Timebase edge polarity
  input  wire [DIV_W-1:0] i_divisor,          // Timebase divide count
  input  wire [15:0]      i_start_delay,      // Ticks start to first sample
  input  wire             i_start_trigger,    // Start trigger, one-cycle pulse
  input  wire             i_start_is_sw,      // Start trigger is software
  input  wire             i_ref_trigger,      // Reference trigger pulse
  input  wire             i_pause_gate,       // Pause gate level
  input  wire             i_pretrig_mode,     // 1 pre-trigger acquisition
  input  wire             i_continuous,       // 1 continuous, no count end
  input  wire             i_sw_stop,          // Software stop pulse
  input  wire [CNT_W-1:0] i_pre_count,        // Pre-trigger sample count
  input  wire [CNT_W-1:0] i_post_count,       // Post-trigger sample count
  input  wire [7:0]       i_conv_count,       // Conversions per sample
  input  wire             i_conversion_pulse, // Conversion done pulse
  input  wire [3:0]       i_route_line_en,    // Route to output lines 6..9
  input  wire [7:0]       i_route_sync_en,    // Route to sync bus lines
  input  wire             i_route_level,      // 1 level form, 0 pulse form
  output reg              o_sample_pulse,     // Accepted sample pulse
  output reg              o_sample_busy,      // Sample in progress
  output reg              o_acq_running,      // Acquisition in progress
  output reg              o_acq_done,         // Acquisition finished pulse
  output reg              o_start_out,        // Start line pulse
  output reg  [3:0]       o_function_line,    // Output-only lines 6..9
  output reg  [7:0]       o_sync_bus_line,    // Sync bus drive value
  output reg  [7:0]       o_sync_bus_oe,      // Sync bus drive enable
  output reg  [CNT_W-1:0] o_sample_count      // Sample counter state
);
  localparam NRAW = 16;  // Raw lines into synchronisers

  // Acquisition states
  localparam ST_IDLE  = 2'h0;
  localparam ST_PRE   = 2'h1;
  localparam ST_ARMED = 2'h2;
  localparam ST_POST  = 2'h3;

  reg  [1:0]  state_q;          // Acquisition state
  reg  [1:0]  state_d;
  reg  [CNT_W-1:0] cnt_d;       // Next sample count
  reg  [DIV_W-1:0] div_q;       // Timebase divider
  reg  [15:0] delay_q;          // Start delay ticks left
  reg         delay_act_q;      // Start delay running
  reg         gen_run_q;        // Internal generator running
  reg  [7:0]  conv_q;           // Conversions still owed
  reg  [7:0]  tb100_q;          // 100 kHz prescaler, 200 cycles needs eight bits
  reg         tb100_tick_q;     // 100 kHz tick
  reg  [3:0]  pw_q;             // Routed pulse stretcher
  wire [NRAW-1:0] rise;         // Rising edges of raw lines
  wire [NRAW-1:0] fall;         // Falling edges of raw lines
  wire        tb_tick;          // Selected timebase tick
  wire        src_edge;         // Selected sample edge
  wire        raw_sample;       // Candidate sample pulse
  wire        accept;           // Sample pulse accepted
  wire        last_conv;        // Final conversion of sample
  wire        route_hi;         // Routed signal level

  // Pick edge of raw line by index and polarity
  function pick;
    input [NRAW-1:0] r;
    input [NRAW-1:0] f;
    input [4:0]      idx;
    input            falling;
    begin
      pick = falling ? f[idx[3:0]] : r[idx[3:0]];
    end
  endfunction

  // Synchronise every raw line; lines 0..5 are inputs only
  wire [NRAW-1:0] raw_lines = {i_bp_clk10, i_star_line,
                               i_sync_bus_line, i_function_line};
  genvar g;
  generate
    for (g = 0; g < NRAW; g = g + 1)
    begin : g_sync
      ast_edge_sync u_rise
      (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_level   (raw_lines[g]),
        .i_falling (1'b0),
        .o_edge    (rise[g])
      );
      ast_edge_sync u_fall
      (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_level   (raw_lines[g]),
        .i_falling (1'b1),
        .o_edge    (fall[g])
      );
    end
  endgenerate

  // 100 kHz internal timebase as an enable pulse
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      tb100_q      <= 8'h00;
      tb100_tick_q <= 1'b0;
    end
    else if (tb100_q == `AST_TB100K_LAST)
    begin
      tb100_q      <= 8'h00;
      tb100_tick_q <= 1'b1;
    end
    else
    begin
      tb100_q      <= tb100_q + 8'h01;
      tb100_tick_q <= 1'b0;
    end
  end

  // Timebase select; it feeds only the divider, never an output
  function tb_pick;
    input [NRAW-1:0] r;
    input [NRAW-1:0] f;
    input [4:0]      sel;
    input            falling;
    input            t100;
    begin
      if (sel == `AST_TB_20MHZ)
        tb_pick = 1'b1; // Every engine cycle
      else if (sel == `AST_TB_100KHZ)
        tb_pick = t100;
      else if (sel == `AST_TB_BP10MHZ)
        tb_pick = pick(r, f, 5'h0F, falling);
      else if (sel >= `AST_TB_SYNC0 && sel < `AST_TB_LINE0)
        tb_pick = pick(r, f, sel - `AST_TB_SYNC0 + 5'h06, falling);
      else if (sel >= `AST_TB_LINE0 && sel < `AST_TB_LINE0 + 5'h06)
        tb_pick = pick(r, f, sel - `AST_TB_LINE0, falling);
      else if (sel == `AST_TB_STAR)
        tb_pick = pick(r, f, 5'h0E, falling);
      else
        tb_pick = 1'b0; // Unused code, no ticks
    end
  endfunction

  assign tb_tick = tb_pick(rise, fall, i_timebase_src, i_timebase_falling,
                           tb100_tick_q);

  // Start delay then divider, armed by start trigger
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      div_q       <= {DIV_W{1'b0}};
      delay_q     <= `AST_START_DLY_RST;
      delay_act_q <= 1'b0;
      gen_run_q   <= 1'b0;
    end
    else if (state_q == ST_IDLE && i_start_trigger)
    begin
      delay_q     <= i_start_delay;
      delay_act_q <= 1'b1;
      gen_run_q   <= 1'b1;
      div_q       <= {DIV_W{1'b0}};
    end
    else if (state_d == ST_IDLE)
    begin
      gen_run_q   <= 1'b0;
      delay_act_q <= 1'b0;
    end
    else if (tb_tick && gen_run_q)
    begin
      if (delay_act_q)
      begin
        // First sample pulse after the delay ticks
        if (delay_q <= 16'h0001)
        begin
          delay_act_q <= 1'b0;
          div_q       <= i_divisor - 1'b1;
        end
        else
          delay_q <= delay_q - 16'h0001;
      end
      else if (div_q == {DIV_W{1'b0}})
        div_q <= i_divisor - 1'b1;
      else
        div_q <= div_q - 1'b1;
    end
  end

  wire div_fire = gen_run_q && tb_tick &&
                  ((delay_act_q && delay_q <= 16'h0001) ||
                   (!delay_act_q && div_q == {DIV_W{1'b0}}));

  // Sample source select with edge polarity
  assign src_edge =
    (i_sample_src == `AST_SRC_COUNTER)  ? i_counter_out :
    (i_sample_src == `AST_SRC_SOFTWARE) ? i_sw_sample :
    (i_sample_src >= `AST_SRC_LINE0 && i_sample_src < `AST_SRC_SYNC0) ?
      pick(rise, fall, i_sample_src - `AST_SRC_LINE0, i_sample_falling) :
    (i_sample_src >= `AST_SRC_SYNC0 && i_sample_src < `AST_SRC_STAR) ?
      pick(rise, fall, i_sample_src - `AST_SRC_SYNC0 + 5'h06, i_sample_falling) :
    (i_sample_src == `AST_SRC_STAR) ?
      pick(rise, fall, 5'h0E, i_sample_falling) : 1'b0;

  assign raw_sample = (i_sample_src == `AST_SRC_DIVIDED) ? div_fire : src_edge;

  // Gate by acquisition, pause and busy; early external pulses get masked
  assign accept = raw_sample && (state_q != ST_IDLE) && !i_pause_gate
                  && !o_sample_busy;

  // Only counted conversions while a sample is busy
  assign last_conv = o_sample_busy && i_conversion_pulse && conv_q <= 8'h01;

  // Acquisition state and sample counter decisions
  always @*
  begin
    state_d = state_q;
    cnt_d   = o_sample_count;
    case (state_q)
      ST_IDLE:
        if (i_start_trigger)
        begin
          state_d = i_pretrig_mode ? ST_PRE : ST_POST;
          cnt_d   = i_pretrig_mode ? i_pre_count : i_post_count;
        end
      ST_PRE:
        if (accept)
        begin
          cnt_d = o_sample_count - 1'b1;
          if (o_sample_count <= {{(CNT_W-1){1'b0}}, 1'b1})
          begin
            state_d = ST_ARMED;
            cnt_d   = i_post_count;
          end
        end
      ST_ARMED:
        if (i_ref_trigger)  // Reference only looked for here
          state_d = ST_POST;
      ST_POST:
        if (accept && !i_continuous)
        begin
          cnt_d = o_sample_count - 1'b1;
          if (o_sample_count <= {{(CNT_W-1){1'b0}}, 1'b1})
            state_d = ST_IDLE;
        end
      default:
        state_d = ST_IDLE;
    endcase
    if (i_sw_stop && state_q != ST_IDLE)
      state_d = ST_IDLE;
  end

  // Acquisition registers and status
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      state_q        <= ST_IDLE;
      o_sample_count <= {CNT_W{1'b0}};
      o_acq_running  <= 1'b0;
      o_acq_done     <= 1'b0;
      o_start_out    <= 1'b0;
      o_sample_pulse <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      o_sample_count <= cnt_d;
      o_acq_running  <= state_d != ST_IDLE;
      o_acq_done     <= state_q != ST_IDLE && state_d == ST_IDLE;
      o_start_out    <= state_q == ST_IDLE && i_start_trigger && i_start_is_sw;
      o_sample_pulse <= accept;
    end
  end

  // Sample busy until the configured conversions arrive
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_sample_busy <= 1'b0;
      conv_q        <= 8'h00;
    end
    else if (accept)
    begin
      // A zero count still holds one conversion
      o_sample_busy <= 1'b1;
      conv_q        <= i_conv_count;
    end
    else if (last_conv)
      o_sample_busy <= 1'b0;
    else if (o_sample_busy && i_conversion_pulse)
      conv_q <= conv_q - 8'h01;
  end

  // Pulse stretcher so the routed pulse is visible off board
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
      pw_q <= 4'h0;
    else if (accept)
      pw_q <= `AST_PULSE_CYC;
    else if (pw_q != 4'h0)
      pw_q <= pw_q - 4'h1;
  end

  assign route_hi = i_route_level ? (accept || (o_sample_busy && !last_conv))
                                  : (accept || pw_q > 4'h1);

  // Routed outputs, active high only
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_function_line <= 4'h0;
      o_sync_bus_line <= 8'h00;
      o_sync_bus_oe   <= 8'h00;
    end
    else
    begin
      o_function_line <= i_route_line_en & {4{route_hi}};
      o_sync_bus_line <= i_route_sync_en & {8{route_hi}};
      o_sync_bus_oe   <= i_route_sync_en;
    end
  end
endmodule // ast_timing_engine
`default_nettype wire

/* verification/ast_conv_model.sv */
/*
  Conversion source model: answers each accepted sample with a train
  of conversion pulses. Assumes the engine's clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ast_conv_model
(
  input  wire logic       i_clock,            // Engine clock
  input  wire logic       i_reset_n,          // Reset, active low
  input  wire logic       i_sample,           // Accepted sample pulse
  input  wire logic [7:0] i_count,            // Conversions per sample
  input  wire logic [3:0] i_gap,              // Extra cycles between pulses
  output var  logic       o_conversion_pulse  // One-cycle conversion pulse
);
  int pending; // Conversions still owed
  int timer;   // Cycles to next conversion
  // Driven at the falling edge so the engine samples a settled pulse
  always @(negedge i_clock)
  begin
    // One assignment per edge: a pulse leaves when the gap runs out
    o_conversion_pulse <= i_reset_n && !i_sample && pending > 0 && timer == 0;
    if (!i_reset_n)
    begin
      pending <= 0;
      timer   <= 0;
    end
    else if (i_sample)
    begin
      pending <= (i_count == 8'h00) ? 1 : i_count;
      timer   <= i_gap + 1;
    end
    else if (pending > 0)
    begin
      if (timer > 0)
        timer <= timer - 1;
      else
      begin
        // Slow gaps stretch the sample, never shorten it
        pending            <= pending - 1;
        timer              <= i_gap + 1;
      end
    end
  end
endmodule // ast_conv_model
`default_nettype wire

/* verification/ast_timing_engine_tb.sv */
/*
  Self-checking bench for the sample timing engine.
  Assumes the conversion model answers every accepted sample.
*/
`timescale 1ns/1ns
`default_nettype none
module ast_timing_engine_tb;
  logic        i_clock, i_reset_n, i_star_line, i_bp_clk10, i_counter_out, i_sw_sample;
  logic        i_sample_falling, i_timebase_falling, i_start_trigger, i_start_is_sw, i_ref_trigger;
  logic        i_pause_gate, i_pretrig_mode, i_continuous, i_sw_stop, i_conversion_pulse, i_route_level;
  logic [5:0]  i_function_line;
  logic [7:0]  i_sync_bus_line, i_conv_count, i_route_sync_en, o_sync_bus_line, o_sync_bus_oe;
  logic [4:0]  i_sample_src, i_timebase_src;
  logic [23:0] i_divisor, i_pre_count, i_post_count, o_sample_count;
  logic [15:0] i_start_delay;
  logic [3:0]  i_route_line_en, o_function_line, gap;
  logic        o_sample_pulse, o_sample_busy, o_acq_running, o_acq_done, o_start_out;
  int          miscompares, checks_done, npulse, ndone, nstart, cyc, tp[$];
  integer      seed;

  ast_timing_engine dut (.*);
  ast_conv_model model (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_sample(o_sample_pulse),
    .i_count(i_conv_count), .i_gap(gap), .o_conversion_pulse(i_conversion_pulse));

  // Clock, 50 ns period
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // Backplane clock kept moving
  // Unknown start resolves to a toggle instead of sticking
  always @(negedge i_clock) i_bp_clk10 <= (i_bp_clk10 !== 1'b1);
  // Event tally with cycle stamps of accepted samples
  always @(posedge i_clock)
  begin
    cyc++;
    if (o_sample_pulse === 1'b1)
    begin
      npulse++;
      tp.push_back(cyc);
    end
    if (o_acq_done === 1'b1) ndone++;
    if (o_start_out === 1'b1) nstart++;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Bounded wait for busy (run=0) or running (run=1) to drop
  task automatic wait_low(input bit run);
    int n;
    n = 0;
    while ((run ? o_acq_running : o_sample_busy) !== 1'b0)
    begin
      tick(1);
      n++;
      if (n > 500)
      begin
        miscompares++;
        $display("Error wait expected 0 seen 1");
        final_report();
      end
    end
  endtask
  // Sets the input that a sample source code listens to
  task automatic drive(input int code, input logic v);
    if (code == 0) i_counter_out = v;
    else if (code == 2) i_sw_sample = v;
    else if (code < 9) i_function_line[code-3] = v;
    else if (code < 17) i_sync_bus_line[code-9] = v;
    else i_star_line = v;
  endtask
  // Pulses are one cycle; lines get a wide pulse to pass synchronisers
  task automatic fire(input int code);
    drive(code, 1'b1);
    tick((code == 0 || code == 2) ? 1 : 6);
    drive(code, 1'b0);
    tick(8);
    wait_low(0);
  endtask
  task automatic start_acq(input logic pre, input logic sw);
    i_pretrig_mode  = pre;
    i_start_is_sw   = sw;
    i_start_trigger = 1'b1;
    tick(1);
    i_start_trigger = 1'b0;
    tick(2);
  endtask
  task automatic stop_acq();
    i_sw_stop = 1'b1;
    tick(1);
    i_sw_stop = 1'b0;
    wait_low(1);
  endtask

  initial
  begin
    int p, q, s0, d0;
    seed = 32'h28FC7177;
    {i_star_line, i_bp_clk10, i_counter_out, i_sw_sample, i_sample_falling, i_timebase_falling} = '0;
    {i_start_trigger, i_start_is_sw, i_ref_trigger, i_pause_gate, i_pretrig_mode} = '0;
    {i_continuous, i_sw_stop, i_route_level, i_reset_n, i_function_line, i_sync_bus_line} = '0;
    {i_route_line_en, i_route_sync_en, i_pre_count, i_post_count, gap} = '0;
    i_sample_src   = 5'h02;
    i_timebase_src = 5'h00;
    i_divisor      = 24'h000008;
    i_start_delay  = 16'h0002;
    i_conv_count   = 8'h01;
    tick(5);
    i_reset_n = 1'b1;
    tick(4);
    // Finite software-timed runs with idle, paused and busy samples
    for (int k = 0; k < 3; k++)
    begin
      q = 1 + ($unsigned($random(seed)) % 4);
      i_post_count    = 24'(q);
      i_conv_count    = (k == 0) ? 8'h03 : 8'(1 + $unsigned($random(seed)) % 3);
      gap             = 4'($unsigned($random(seed)) % 3);
      i_route_line_en = 4'($random(seed)) | 4'h1;
      i_route_sync_en = 8'($random(seed));
      i_route_level   = (k != 1);
      s0 = npulse;
      d0 = ndone;
      fire(2);
      check_val("idle sample", s0, npulse);
      p = nstart;
      start_acq(1'b0, 1'b1);
      check_val("start echo", p + 1, nstart);
      i_pause_gate = 1'b1;
      tick(4);
      fire(2);
      i_pause_gate = 1'b0;
      tick(4);
      check_val("paused sample", s0, npulse);
      for (int n = 0; n < 8 && o_acq_running === 1'b1; n++)
      begin
        // Second request lands while the first is still converting
        drive(2, 1'b1);
        tick(1);
        drive(2, 1'b0);
        tick(1);
        drive(2, 1'b1);
        tick(1);
        drive(2, 1'b0);
        tick(2);
        wait_low(0);
        tick(2);
      end
      check_val("post samples", s0 + q, npulse);
      check_val("done pulses", d0 + 1, ndone);
      check_val("run ended", 0, o_acq_running);
    end
    // Pre-trigger run with an early reference trigger
    p = 1 + ($unsigned($random(seed)) % 3);
    q = 1 + ($unsigned($random(seed)) % 3);
    i_pre_count  = 24'(p);
    i_post_count = 24'(q);
    s0 = npulse;
    d0 = nstart;
    start_acq(1'b1, 1'b0);
    check_val("hw start echo", d0, nstart);
    i_ref_trigger = 1'b1;
    tick(1);
    i_ref_trigger = 1'b0;
    repeat (p) fire(2);
    check_val("pre samples", s0 + p, npulse);
    check_val("pre running", 1, o_acq_running);
    i_ref_trigger = 1'b1;
    tick(1);
    i_ref_trigger = 1'b0;
    tick(4);
    for (int n = 0; n < 8 && o_acq_running === 1'b1; n++) fire(2);
    check_val("ref post samples", s0 + p + q, npulse);
    // Every sample source but divided in a continuous run, unrouted outputs
    {i_continuous, i_route_line_en, i_route_sync_en, gap, i_conv_count} = {1'b1, 16'h0000, 8'h01};
    start_acq(1'b0, 1'b0);
    for (int c = 0; c < 18; c++)
      if (c != 1)
      begin
        i_sample_src = 5'(c);
        tick(1);
        s0 = npulse;
        fire(c);
        check_val("source sample", s0 + 1, npulse);
      end
    i_sample_src     = 5'h03;
    i_sample_falling = 1'b1;
    tick(1);
    s0 = npulse;
    drive(3, 1'b1);
    tick(8);
    check_val("rise ignored", s0, npulse);
    drive(3, 1'b0);
    tick(8);
    check_val("fall taken", s0 + 1, npulse);
    i_sample_falling = 1'b0;
    stop_acq();
    check_val("stopped", 0, o_acq_running);
    // Divided timebase: spacing of samples equals the divisor
    p = 6 + ($unsigned($random(seed)) % 4);
    i_divisor    = 24'(p);
    i_sample_src = 5'h01;
    start_acq(1'b0, 1'b0);
    d0 = cyc - 2;
    tp.delete();
    for (int n = 0; n < 200 && tp.size() < 3; n++) tick(1);
    check_val("divided period", p, tp[2] - tp[1]);
    // Start edge, delay ticks, then one cycle to the registered pulse
    check_val("start delay", i_start_delay + 1, tp[0] - d0);
    // Backplane clock as timebase on its falling edge: two cycles a tick
    i_timebase_src     = 5'h02;
    i_timebase_falling = 1'b1;
    tick(1);
    tp.delete();
    for (int n = 0; n < 200 && tp.size() < 3; n++) tick(1);
    check_val("slow timebase", 2 * p, tp[2] - tp[1]);
    stop_acq();
    final_report();
  end
endmodule // ast_timing_engine_tb
`default_nettype wire

/* verification/ast_timing_props.sv */
/*
  Concurrent checks on the sample timing engine's ports.
  Assumes one clock domain and binding onto every engine instance.
*/
`timescale 1ns/1ns
`default_nettype none
module ast_timing_props
#(
  parameter CNT_W = 24,
  parameter DIV_W = 24
)
(
  input wire logic             i_clock, i_reset_n, i_start_trigger, i_start_is_sw,
  input wire logic             i_pause_gate, i_pretrig_mode, i_continuous, i_route_level,
  input wire logic [CNT_W-1:0] i_pre_count, i_post_count,
  input wire logic [3:0]       i_route_line_en,
  input wire logic [7:0]       i_route_sync_en,
  input wire logic             o_sample_pulse, o_sample_busy, o_acq_running, o_acq_done, o_start_out,
  input wire logic [3:0]       o_function_line,
  input wire logic [7:0]       o_sync_bus_line, o_sync_bus_oe,
  input wire logic [CNT_W-1:0] o_sample_count
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Finite post-trigger run, where the count must walk down by one
  wire fin = !i_pretrig_mode && !i_continuous;
  wire lvl = i_route_level && i_route_line_en[0];

  chk_idle_sample_drop: assert property (o_sample_pulse |-> $past(o_acq_running))
    else $error("sample pulse outside acquisition");
  // Pause gates acceptance directly, so one cycle of it must block
  chk_pause_blocks: assert property (i_pause_gate |=> !o_sample_pulse)
    else $error("sample pulse while paused");
  chk_busy_blocks: assert property (o_sample_pulse |-> !$past(o_sample_busy))
    else $error("sample accepted while busy");
  chk_start_echo: assert property (i_start_trigger && i_start_is_sw && !o_acq_running |=> o_start_out)
    else $error("software start not echoed");
  chk_start_cause: assert property (o_start_out |-> $past(i_start_trigger) && $past(i_start_is_sw))
    else $error("start echo without software start");
  chk_start_runs: assert property (i_start_trigger && !o_acq_running |=> o_acq_running)
    else $error("start trigger did not start");
  chk_count_load: assert property (i_start_trigger && !o_acq_running && !i_continuous |=>
    o_sample_count == ($past(i_pretrig_mode) ? $past(i_pre_count) : $past(i_post_count)))
    else $error("sample counter load wrong");
  chk_count_step: assert property (o_sample_pulse && fin |-> o_sample_count == $past(o_sample_count) - 1'b1)
    else $error("sample counter did not step");
  chk_final_done: assert property (o_sample_pulse && fin && o_sample_count == '0 |-> o_acq_done && !o_acq_running)
    else $error("acquisition did not end at zero");
  chk_route_pulse: assert property ($rose(o_function_line[0]) && !i_route_level && !$past(i_route_level)
    |=> o_function_line[0] ##1 !o_function_line[0])
    else $error("routed pulse width wrong");
  chk_route_level: assert property ((o_sample_busy && lvl) [*3] |-> $past(o_function_line[0]))
    else $error("routed level dropped in sample");
  chk_line_off: assert property ((i_route_line_en == 4'h0) [*3] |-> o_function_line == 4'h0)
    else $error("output line driven unrouted");
  chk_sync_off: assert property ((i_route_sync_en == 8'h00) [*3] |-> o_sync_bus_oe == 8'h00)
    else $error("sync bus driven unrouted");
  chk_sync_mask: assert property ((o_sync_bus_line & ~o_sync_bus_oe) == 8'h00)
    else $error("sync bus line high while not enabled");
  chk_sync_follow: assert property (o_function_line[0] |-> o_sync_bus_line == o_sync_bus_oe)
    else $error("sync bus not following routed sample");

  cov_done: cover property (o_acq_done);
  cov_start: cover property (o_start_out);
  cov_level: cover property (o_sample_pulse && i_route_level);
endmodule // ast_timing_props
bind ast_timing_engine ast_timing_props #(.CNT_W(CNT_W), .DIV_W(DIV_W)) u_props (.*);
`default_nettype wire
